/* File: logic/pwm_ctl_pkg.sv */
// Constants, register map and types shared by the PWM generator control slice.
// What this block does
// RULE1: Dead-time field 11 selects dead-time compensation mode.
// RULE2: Dead-time field 10 inserts no dead time between high and low outputs.
// RULE3: Dead-time field 01 applies negative dead time, complementary output mode only.
// RULE4: Dead-time field 00 applies positive dead time in every output mode.
// RULE5: Polarity one: compensation low shortens low output, high shortens high output.
// RULE6: Polarity zero: compensation low shortens high output, high shortens low output.
// RULE7: Compensation polarity is ignored unless the dead-time field is 11.
// RULE8: Alignment bit one selects center-aligned counting, zero selects edge-aligned.
// RULE9: Center alignment only takes effect with the independent time base enabled.
// RULE10: External reset bit plus independent time base lets current limit reset time base.
// RULE11: Software enables independent time base and clears current-limit mode for external reset.
// RULE12: Immediate-update bit one makes duty, dead-time and phase writes act at once.
// RULE13: Immediate-update bit zero defers those values to the next period boundary.
// RULE14: Software clears the interrupt flag here and in the interrupt controller.
// RULE15: Software should not change alignment once the module is switched on.
// RULE16: Control bits 4 and 3 read as zero and ignore writes.
`default_nettype none
package pwm_ctl_pkg;

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] CFG_OFS = 8'h04;
	localparam logic [7:0] PERIOD_OFS = 8'h08;
	localparam logic [7:0] IRQ_STAT_OFS = 8'h20;
	localparam logic [7:0] IRQ_MASK_OFS = 8'h24;
	localparam logic [7:0] STATE_OFS = 8'h28;

	// Double-buffered values: duty, master duty, dead time, alternate dead time, phase.
	localparam int NUM_SHADOW = 5;
	localparam int SH_DUTY = 0;
	localparam int SH_MDUTY = 1;
	localparam int SH_DEAD = 2;
	localparam int SH_ALT = 3;
	localparam int SH_PHASE = 4;
	localparam logic [7:0] SHADOW_OFS [NUM_SHADOW] = '{8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};

	// ****************************************
	// Field positions
	// ****************************************
	localparam int CTRL_DTM_LSB = 6;
	localparam int CTRL_POL_BIT = 5;
	localparam int CTRL_CAM_BIT = 2;
	localparam int CTRL_XRES_BIT = 1;
	localparam int CTRL_IMM_BIT = 0;
	localparam logic [15:0] CTRL_WMASK = 16'h00e7;
	localparam int CFG_ON_BIT = 0;
	localparam int CFG_ITB_BIT = 1;
	localparam int CFG_CURRENT_LIMIT_MODE_BIT = 2;
	localparam int CFG_COMPL_BIT = 3;
	localparam int CFG_MDC_BIT = 4;
	localparam logic [15:0] CFG_WMASK = 16'h001f;
	localparam int IRQ_PERIOD_BIT = 0;
	localparam int IRQ_LIMIT_BIT = 1;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] CFG_RESET = 16'h0008;
	localparam logic [15:0] PERIOD_RESET = 16'h0063;
	localparam logic [15:0] SHADOW_RESET = 16'h0000;

	// ****************************************
	// Dead-time mode codes
	// ****************************************
	localparam logic [1:0] DTM_POS = 2'b00;
	localparam logic [1:0] DTM_NEG = 2'b01;
	localparam logic [1:0] DTM_OFF = 2'b10;
	localparam logic [1:0] DTM_COMP = 2'b11;

	typedef enum logic [1:0] {TB_IDLE, TB_UP, TB_DOWN} tb_state_e;

endpackage
`default_nettype wire

/* File: logic/pin_filter.sv */
// Three-stage pin synchroniser that only accepts a level both late stages agree on.
`timescale 1ns/1ps
`default_nettype none
module pin_filter (
	input wire logic mclk, // System clock.
	input wire logic sys_rst, // Synchronous reset, active high.
	input wire logic pin_in, // Asynchronous pin level.
	output var logic level // Filtered level.
);

	logic s1_q;
	logic s2_q;
	logic s3_q;

	// The first stage feeds only the second; a short glitch must survive two samples to count.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			level <= 1'b0;
		end else begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				level <= s3_q;
			end
		end
	end

endmodule
`default_nettype wire

/* File: logic/pwm_gen_ctl.sv */
// PWM generator control slice: APB registers, time base, dead-time and output stage.
`timescale 1ns/1ps
`default_nettype none
module pwm_gen_ctl (
	input wire logic mclk, // System clock, 10 MHz.
	input wire logic sys_rst, // Synchronous reset, active high.
	input wire logic psel, // APB select.
	input wire logic penable, // APB enable.
	input wire logic pwrite, // APB direction, high for write.
	input wire logic [7:0] paddr, // APB byte address.
	input wire logic [31:0] pwdata, // APB write data.
	output var logic [31:0] prdata, // APB read data.
	output var logic pready, // APB ready.
	output var logic pslverr, // APB error for unmapped address.
	input wire logic deadtime_comp_input, // Dead-time compensation pin.
	input wire logic current_limit_src, // Current-limit source, active high.
	output var logic pwm_out_high, // High-side gate output.
	output var logic pwm_out_low, // Low-side gate output.
	output var logic irq // Level interrupt, active high.
);
	import pwm_ctl_pkg::*;

	// ****************************************
	// Declarations
	// ****************************************
	logic [15:0] ctrl_q;
	logic [15:0] cfg_q;
	logic [15:0] period_q;
	logic [15:0] pend_q [NUM_SHADOW];
	logic [15:0] act_q [NUM_SHADOW];
	logic [1:0] irq_stat_q;
	logic [1:0] irq_mask_q;
	logic [1:0] irq_ev;
	logic [15:0] cnt_q;
	logic [15:0] since_q;
	tb_state_e tb_q;
	logic raw_d;
	logic raw_q;
	logic seen_q;
	logic ext_prev_q;
	logic comp_f;
	logic limit_f;
	logic setup;
	logic wr_en;
	logic addr_ok;
	logic [31:0] rd_val;
	logic on;
	logic independent_timebase_en;
	logic center;
	logic imm;
	logic ext_rst;
	logic boundary;
	logic [1:0] dtm;
	logic sh_high;
	logic high_c;
	logic low_c;
	logic [15:0] duty_sel;

	// ****************************************
	// Pin inputs
	// ****************************************
	pin_filter u_comp_pin (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.pin_in(deadtime_comp_input),
		.level(comp_f)
	);

	pin_filter u_limit_pin (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.pin_in(current_limit_src),
		.level(limit_f)
	);

	// ****************************************
	// APB slave
	// ****************************************
	// Zero-wait slave: read data is captured in setup, so the answer is ready in the access cycle.
	assign setup = psel & ~penable;
	assign wr_en = psel & penable & pwrite & pready & addr_ok;

	// Address decode and read mux; unmapped addresses answer with an error.
	always_comb begin
		rd_val = 32'h0;
		addr_ok = 1'b1;
		case (paddr)
			CTRL_OFS: rd_val = {16'h0, ctrl_q};
			CFG_OFS: rd_val = {16'h0, cfg_q};
			PERIOD_OFS: rd_val = {16'h0, period_q};
			SHADOW_OFS[SH_DUTY]: rd_val = {16'h0, pend_q[SH_DUTY]};
			SHADOW_OFS[SH_MDUTY]: rd_val = {16'h0, pend_q[SH_MDUTY]};
			SHADOW_OFS[SH_DEAD]: rd_val = {16'h0, pend_q[SH_DEAD]};
			SHADOW_OFS[SH_ALT]: rd_val = {16'h0, pend_q[SH_ALT]};
			SHADOW_OFS[SH_PHASE]: rd_val = {16'h0, pend_q[SH_PHASE]};
			IRQ_STAT_OFS: rd_val = {30'h0, irq_stat_q};
			IRQ_MASK_OFS: rd_val = {30'h0, irq_mask_q};
			STATE_OFS: rd_val = {cnt_q, 11'h0, (tb_q == TB_DOWN), comp_f, limit_f, pwm_out_high, pwm_out_low};
			default: addr_ok = 1'b0;
		endcase
	end

	// Bus answer registers; error flag holds through the access phase and clears after it.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			if (setup) begin
				prdata <= rd_val;
				pslverr <= ~addr_ok;
			end else if (pready) begin
				pslverr <= 1'b0;
			end
		end
	end

	// ****************************************
	// Control and configuration registers
	// ****************************************
	// Unimplemented control bits are masked off on write and so always read zero.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ctrl_q <= CTRL_RESET;
			cfg_q <= CFG_RESET;
			period_q <= PERIOD_RESET;
		end else if (wr_en) begin
			if (paddr == CTRL_OFS) begin
				ctrl_q <= pwdata[15:0] & CTRL_WMASK; // RULE16
			end
			if (paddr == CFG_OFS) begin
				cfg_q <= pwdata[15:0] & CFG_WMASK;
			end
			if (paddr == PERIOD_OFS) begin
				period_q <= pwdata[15:0];
			end
		end
	end

	assign on = cfg_q[CFG_ON_BIT];
	assign independent_timebase_en = cfg_q[CFG_ITB_BIT];
	assign imm = ctrl_q[CTRL_IMM_BIT];
	assign dtm = ctrl_q[CTRL_DTM_LSB +: 2];
	assign center = independent_timebase_en & ctrl_q[CTRL_CAM_BIT]; // RULE8 RULE9
	// External reset also needs current-limit mode off, otherwise the source leaves the time base and outputs alone.
	assign ext_rst = on & independent_timebase_en & ctrl_q[CTRL_XRES_BIT] & ~cfg_q[CFG_CURRENT_LIMIT_MODE_BIT] & limit_f; // RULE10 RULE11

	// ****************************************
	// Double-buffered values
	// ****************************************
	// Each value has a software copy and an active copy used by the generator.
	for (genvar i = 0; i < NUM_SHADOW; i++) begin : g_shadow
		always_ff @(posedge mclk) begin
			if (sys_rst) begin
				pend_q[i] <= SHADOW_RESET;
				act_q[i] <= SHADOW_RESET;
			end else begin
				if (wr_en && paddr == SHADOW_OFS[i]) begin
					pend_q[i] <= pwdata[15:0];
				end
				if (wr_en && paddr == SHADOW_OFS[i] && imm) begin
					act_q[i] <= pwdata[15:0]; // RULE12
				end else if (boundary) begin
					act_q[i] <= pend_q[i]; // RULE13
				end
			end
		end
	end

	// ****************************************
	// Time base
	// ****************************************
	// A boundary is the period wrap, the bottom of a center-aligned cycle, or the start.
	always_comb begin
		boundary = 1'b0;
		if (on && !ext_rst) begin
			case (tb_q)
				TB_IDLE: boundary = 1'b1;
				TB_UP: boundary = (cnt_q >= period_q) && !(center && period_q != 16'h0);
				TB_DOWN: boundary = (cnt_q == 16'h0);
				default: boundary = 1'b0;
			endcase
		end
	end

	// Up counter, or up/down in center-aligned mode; the limit source holds it at phase.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cnt_q <= 16'h0;
			tb_q <= TB_IDLE;
		end else if (!on) begin
			cnt_q <= 16'h0;
			tb_q <= TB_IDLE;
		end else if (ext_rst) begin
			cnt_q <= act_q[SH_PHASE]; // RULE10
			tb_q <= TB_UP;
		end else begin
			case (tb_q)
				TB_IDLE: begin
					cnt_q <= act_q[SH_PHASE];
					tb_q <= TB_UP;
				end
				TB_UP: begin
					if (cnt_q >= period_q) begin
						if (center && period_q != 16'h0) begin
							cnt_q <= cnt_q - 16'h1; // RULE8
							tb_q <= TB_DOWN;
						end else begin
							cnt_q <= 16'h0;
						end
					end else begin
						cnt_q <= cnt_q + 16'h1;
					end
				end
				TB_DOWN: begin
					// Dropping center mode mid-cycle simply resumes counting up.
					if (cnt_q == 16'h0 || !center) begin
						cnt_q <= cnt_q + 16'h1;
						tb_q <= TB_UP; // RULE9
					end else begin
						cnt_q <= cnt_q - 16'h1;
					end
				end
				default: tb_q <= TB_IDLE;
			endcase
		end
	end

	// ****************************************
	// Raw duty comparison and edge timer
	// ****************************************
	assign duty_sel = cfg_q[CFG_MDC_BIT] ? act_q[SH_MDUTY] : act_q[SH_DUTY];
	assign raw_d = on && (cnt_q < duty_sel);

	// The timer counts cycles since the last raw edge and saturates rather than wrapping.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			raw_q <= 1'b0;
			since_q <= 16'h0;
			seen_q <= 1'b0;
		end else begin
			raw_q <= raw_d;
			if (raw_d != raw_q) begin
				since_q <= 16'h0;
			end else if (since_q != 16'hffff) begin
				since_q <= since_q + 16'h1;
			end
			if (!on) begin
				seen_q <= 1'b0;
			end else if (raw_d != raw_q) begin
				seen_q <= 1'b1;
			end
		end
	end

	// ****************************************
	// Dead-time and output stage
	// ****************************************
	// Output the compensation pin chooses to shorten; polarity only matters in mode 11.
	assign sh_high = ctrl_q[CTRL_POL_BIT] ? comp_f : ~comp_f; // RULE5 RULE6

	// Non-complementary mode drives both outputs alike, so negative dead time is not applied there.
	always_comb begin
		high_c = raw_q;
		low_c = ~raw_q;
		case (dtm)
			DTM_POS: begin
				high_c = raw_q && (since_q >= act_q[SH_DEAD]); // RULE4
				low_c = !raw_q && (since_q >= act_q[SH_ALT]);
			end
			DTM_NEG: begin
				high_c = raw_q || (seen_q && since_q < act_q[SH_DEAD]); // RULE3
				low_c = !raw_q || (seen_q && since_q < act_q[SH_ALT]);
			end
			DTM_OFF: begin
				high_c = raw_q; // RULE2
				low_c = ~raw_q;
			end
			DTM_COMP: begin
				high_c = raw_q && (!sh_high || since_q >= act_q[SH_DEAD]); // RULE1 RULE7
				low_c = !raw_q && (sh_high || since_q >= act_q[SH_DEAD]);
			end
			default: begin
				high_c = raw_q;
				low_c = ~raw_q;
			end
		endcase
		if (!cfg_q[CFG_COMPL_BIT]) begin
			if (dtm == DTM_NEG) begin
				high_c = raw_q; // RULE3
			end
			low_c = high_c;
		end
		if (!on) begin
			high_c = 1'b0;
			low_c = 1'b0;
		end
	end

	// Registered gate outputs.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			pwm_out_high <= 1'b0;
			pwm_out_low <= 1'b0;
		end else begin
			pwm_out_high <= high_c;
			pwm_out_low <= low_c;
		end
	end

	// ****************************************
	// Interrupts
	// ****************************************
	assign irq_ev[IRQ_PERIOD_BIT] = boundary;
	assign irq_ev[IRQ_LIMIT_BIT] = ext_rst & ~ext_prev_q;

	// Sticky flags cleared by writing one; a new event in the same cycle wins.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			irq_stat_q <= 2'b00;
			irq_mask_q <= 2'b00;
			ext_prev_q <= 1'b0;
			irq <= 1'b0;
		end else begin
			ext_prev_q <= ext_rst;
			if (wr_en && paddr == IRQ_STAT_OFS) begin
				irq_stat_q <= (irq_stat_q & ~pwdata[1:0]) | irq_ev; // RULE14
			end else begin
				irq_stat_q <= irq_stat_q | irq_ev;
			end
			if (wr_en && paddr == IRQ_MASK_OFS) begin
				irq_mask_q <= pwdata[1:0];
			end
			irq <= |(irq_stat_q & irq_mask_q);
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);

	sequence s_rise_shortened;
		$rose(raw_q) && on && dtm == DTM_COMP && act_q[SH_DEAD] != 16'h0;
	endsequence

	sequence s_fall_negative;
		$fell(raw_q) && on && dtm == DTM_NEG && cfg_q[CFG_COMPL_BIT] && seen_q && act_q[SH_DEAD] != 16'h0;
	endsequence

	comp_mode_a: assert property (s_rise_shortened ##0 sh_high |=> !pwm_out_high) // RULE1
		else $error("Shortened high output rose without dead time.");
	comp_pol_one_a: assert property (s_rise_shortened ##0 ctrl_q[CTRL_POL_BIT] && !comp_f |=> pwm_out_high) // RULE5
		else $error("Lengthened high output was delayed.");
	comp_pol_zero_a: assert property (s_rise_shortened ##0 !ctrl_q[CTRL_POL_BIT] && !comp_f |=> !pwm_out_high) // RULE6
		else $error("High output not shortened with polarity zero.");
	no_dead_a: assert property (on && dtm == DTM_OFF && cfg_q[CFG_COMPL_BIT] |=> pwm_out_high == $past(raw_q) && pwm_out_low != pwm_out_high) // RULE2
		else $error("Outputs not plain complements with dead time off.");
	neg_dead_a: assert property (s_fall_negative |=> pwm_out_high && pwm_out_low) // RULE3
		else $error("Negative dead time did not overlap outputs.");
	pos_dead_a: assert property ($rose(raw_q) && on && dtm == DTM_POS && act_q[SH_DEAD] != 16'h0 |=> !pwm_out_high && !pwm_out_low) // RULE4
		else $error("Positive dead time missing on rising edge.");
	pol_ignored_a: assert property (on && dtm == DTM_POS && $stable(ctrl_q) && $stable(cfg_q) && $stable(act_q[SH_DEAD]) // RULE7
		&& $changed(comp_f) && !$rose(raw_q) && !$fell(raw_q) && since_q != act_q[SH_DEAD] |=> $stable(pwm_out_high))
		else $error("Compensation input affected output outside mode 11.");
	center_turn_a: assert property (on && !ext_rst && center && tb_q == TB_UP && cnt_q >= period_q && period_q != 16'h0 |=> tb_q == TB_DOWN) // RULE8
		else $error("Center-aligned count did not turn at period.");
	itb_center_a: assert property (on && !independent_timebase_en && tb_q == TB_DOWN |=> tb_q == TB_UP) // RULE9
		else $error("Down count persisted without independent time base.");
	ext_reset_a: assert property (ext_rst |=> cnt_q == $past(act_q[SH_PHASE]) && tb_q == TB_UP) // RULE10
		else $error("Current limit did not reset the time base.");
	imm_update_a: assert property (wr_en && paddr == SHADOW_OFS[SH_DUTY] && imm |=> act_q[SH_DUTY] == $past(pwdata[15:0])) // RULE12
		else $error("Immediate duty update missed.");
	defer_update_a: assert property (wr_en && paddr == SHADOW_OFS[SH_DUTY] && !imm && !boundary |=> $stable(act_q[SH_DUTY])) // RULE13
		else $error("Deferred duty changed before period boundary.");
	unimpl_bits_a: assert property (setup && !pwrite && paddr == CTRL_OFS |=> prdata[4:3] == 2'b00 && pready) // RULE16
		else $error("Unimplemented control bits read nonzero.");

endmodule
`default_nettype wire

/* File: tb/pwr_stage_model.sv */
// Power stage model: gate drivers with on-time counters and the sense inputs.
`timescale 1ns/1ps
`default_nettype none
module pwr_stage_model (
	input wire logic mclk, // System clock.
	input wire logic clr, // Clears the on-time counters.
	input wire logic limit_cmd, // Bench request for over-current.
	input wire logic comp_cmd, // Bench level of the current sense.
	input wire logic pwm_out_high, // High-side gate.
	input wire logic pwm_out_low, // Low-side gate.
	output logic current_limit_src, // Over-current sense to the block.
	output logic deadtime_comp_input, // Current-direction sense to the block.
	output logic [15:0] high_cnt, // Cycles with the high gate on.
	output logic [15:0] low_cnt, // Cycles with the low gate on.
	output logic [15:0] idle_cnt // Cycles with both gates off.
);
	// The sense lines follow the bench at once; the block filters them itself.
	assign current_limit_src = limit_cmd;
	assign deadtime_comp_input = comp_cmd;

	// On-time counters; whole periods give exact dead-time totals whatever the phase.
	always_ff @(posedge mclk) begin
		if (clr) begin
			high_cnt <= 16'h0000;
			low_cnt <= 16'h0000;
			idle_cnt <= 16'h0000;
		end else begin
			high_cnt <= high_cnt + {15'h0000, pwm_out_high};
			low_cnt <= low_cnt + {15'h0000, pwm_out_low};
			idle_cnt <= idle_cnt + {15'h0000, ~(pwm_out_high | pwm_out_low)};
		end
	end
endmodule
`default_nettype wire

/* File: tb/test_pwm_gen_ctl.sv */
// Self-checking bench for the PWM generator control slice.
`timescale 1ns/1ps
`default_nettype none
module test_pwm_gen_ctl;
	import pwm_ctl_pkg::*;
	logic mclk, sys_rst, psel, penable, pwrite, clr, limit_cmd, comp_cmd;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic pready, pslverr, comp_in, limit_src, hi, lo, irq;
	logic [15:0] high_cnt, low_cnt, idle_cnt;
	int errors, total_checks;

	pwm_gen_ctl u_dut (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.deadtime_comp_input(comp_in), .current_limit_src(limit_src), .pwm_out_high(hi),
		.pwm_out_low(lo), .irq(irq));
	pwr_stage_model u_stage (.mclk(mclk), .clr(clr), .limit_cmd(limit_cmd), .comp_cmd(comp_cmd),
		.pwm_out_high(hi), .pwm_out_low(lo), .current_limit_src(limit_src),
		.deadtime_comp_input(comp_in), .high_cnt(high_cnt), .low_cnt(low_cnt), .idle_cnt(idle_cnt));

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic end_sim();
		if (errors == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask

	// One APB transfer; the request is held until pready is seen high.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic e);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			errors++;
			end_sim();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic ee);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		chk(q, exp, "read data");
		chk({31'h0, e}, {31'h0, ee}, "slave error");
	endtask

	// Counts five whole periods of ten cycles after the outputs settle.
	task automatic measure(input logic [15:0] eh, input logic [15:0] el, input logic [15:0] ei);
		repeat (12) @(posedge mclk);
		clr <= 1'b1;
		@(posedge mclk);
		clr <= 1'b0;
		repeat (50) @(posedge mclk);
		#1;
		chk({16'h0, high_cnt}, {16'h0, eh}, "high on-time");
		if (el !== 16'hffff) chk({16'h0, low_cnt}, {16'h0, el}, "low on-time");
		chk({16'h0, idle_cnt}, {16'h0, ei}, "idle time");
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_regs();
		rdc(CTRL_OFS, 32'h0, 1'b0);
		rdc(CFG_OFS, 32'h8, 1'b0);
		rdc(PERIOD_OFS, 32'h63, 1'b0);
		wr(CTRL_OFS, 32'hffff_ffff);
		rdc(CTRL_OFS, 32'h0000_00e7, 1'b0);
		wr(8'h2c, 32'hffff_ffff);
		rdc(8'h2c, 32'h0, 1'b1);
	endtask

	// Period 10 cycles, duty 4, dead time 1, alternate dead time 2.
	task automatic t_dead();
		wr(CTRL_OFS, 32'h1);
		wr(PERIOD_OFS, 32'h9);
		wr(SHADOW_OFS[SH_DUTY], 32'h4);
		wr(SHADOW_OFS[SH_DEAD], 32'h1);
		wr(SHADOW_OFS[SH_ALT], 32'h2);
		wr(CFG_OFS, 32'h9);
		measure(16'd15, 16'd20, 16'd15);
		comp_cmd <= 1'b1;
		wr(CTRL_OFS, 32'h21);
		measure(16'd15, 16'd20, 16'd15);
		comp_cmd <= 1'b0;
		wr(CTRL_OFS, 32'h81);
		measure(16'd20, 16'd30, 16'd0);
		wr(CTRL_OFS, 32'h41);
		measure(16'd25, 16'd40, 16'd0);
		wr(CFG_OFS, 32'h1);
		measure(16'd20, 16'd20, 16'd30);
		wr(SHADOW_OFS[SH_MDUTY], 32'h6);
		wr(CFG_OFS, 32'h19);
		measure(16'd35, 16'd30, 16'd0);
		wr(CFG_OFS, 32'h9);
		for (int i = 0; i < 4; i++) begin
			comp_cmd <= i[0];
			wr(CTRL_OFS, {24'h0, 2'b11, i[1], 5'h01});
			measure((i[0] == i[1]) ? 16'd15 : 16'd20, (i[0] == i[1]) ? 16'd30 : 16'd25, 16'd5);
		end
		comp_cmd <= 1'b0;
	endtask

	task automatic align(input logic [31:0] cfg, input logic [31:0] ctl, input logic exp);
		logic [31:0] q;
		logic e;
		logic seen;
		wr(CFG_OFS, 32'h8); // Alignment is only changed with the module off.
		wr(CTRL_OFS, ctl);
		wr(CFG_OFS, cfg);
		seen = 1'b0;
		repeat (25) begin
			apb(1'b0, STATE_OFS, 32'h0, q, e);
			seen = seen | q[4];
		end
		chk({31'h0, seen}, {31'h0, exp}, "count direction");
	endtask

	task automatic t_limit();
		logic [31:0] a, b;
		logic e;
		wr(SHADOW_OFS[SH_PHASE], 32'h3);
		wr(CTRL_OFS, 32'h83);
		wr(CFG_OFS, 32'hb); // Own time base, current-limit mode off.
		wr(IRQ_STAT_OFS, 32'h3);
		wr(IRQ_MASK_OFS, 32'h2);
		limit_cmd <= 1'b1;
		repeat (8) @(posedge mclk);
		apb(1'b0, STATE_OFS, 32'h0, a, e);
		repeat (5) @(posedge mclk);
		apb(1'b0, STATE_OFS, 32'h0, b, e);
		chk({16'h0, a[31:16]}, 32'h3, "held count");
		chk({16'h0, b[31:16]}, 32'h3, "held count");
		chk({31'h0, irq}, 32'h1, "limit interrupt");
		wr(IRQ_STAT_OFS, 32'h2); // Software clears the flag in the block.
		@(posedge mclk);
		#1;
		chk({31'h0, irq}, 32'h0, "masked interrupt");
		wr(CTRL_OFS, 32'h81);
		apb(1'b0, STATE_OFS, 32'h0, a, e);
		repeat (5) @(posedge mclk);
		apb(1'b0, STATE_OFS, 32'h0, b, e);
		chk({31'h0, a[31:16] !== b[31:16]}, 32'h1, "count runs");
		wr(CFG_OFS, 32'hf); // Current-limit mode on keeps the limit from resetting the count.
		wr(CTRL_OFS, 32'h83);
		apb(1'b0, STATE_OFS, 32'h0, a, e);
		repeat (5) @(posedge mclk);
		apb(1'b0, STATE_OFS, 32'h0, b, e);
		chk({31'h0, a[31:16] !== b[31:16]}, 32'h1, "count runs");
		wr(CFG_OFS, 32'hb);
		limit_cmd <= 1'b0;
		wr(IRQ_MASK_OFS, 32'h0);
	endtask

	// Writes duty early in a long period and looks at the high gate.
	task automatic upd(input logic [31:0] ctl, input logic early);
		logic [31:0] q;
		logic e;
		int n;
		wr(CTRL_OFS, ctl);
		n = 0;
		do begin
			apb(1'b0, STATE_OFS, 32'h0, q, e);
			n++;
		end while (q[31:16] > 16'd30 && n < 80);
		if (q[31:16] > 16'd30) begin
			errors++;
			end_sim();
		end
		wr(SHADOW_OFS[SH_DUTY], 32'h63);
		repeat (3) @(posedge mclk);
		#1;
		chk({31'h0, hi}, {31'h0, early}, "gate after write");
		n = 0;
		while (hi !== 1'b1 && n < 120) begin
			@(posedge mclk);
			n++;
		end
		chk({31'h0, hi}, 32'h1, "gate at boundary");
		if (hi !== 1'b1) begin
			end_sim();
		end
		wr(CTRL_OFS, 32'h81);
		wr(SHADOW_OFS[SH_DUTY], 32'h0);
	endtask

	// ****************************************
	// Clock, reset and main sequence
	// ****************************************
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	initial begin
		sys_rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		clr = 1'b0;
		limit_cmd = 1'b0;
		comp_cmd = 1'b0;
		errors = 0;
		total_checks = 0;
		repeat (16) @(posedge mclk);
		sys_rst <= 1'b0;
		t_regs();
		t_dead();
		align(32'hb, 32'h85, 1'b1);
		wr(CFG_OFS, 32'h9);
		align(32'h9, 32'h85, 1'b0);
		align(32'hb, 32'h81, 1'b0);
		t_limit();
		wr(CFG_OFS, 32'h9);
		wr(PERIOD_OFS, 32'h63);
		wr(SHADOW_OFS[SH_DUTY], 32'h0);
		upd(32'h80, 1'b0);
		upd(32'h81, 1'b1);
		end_sim();
	end
endmodule
`default_nettype wire
